// ===== hdl/mmx_pkg.sv
// Package of constants and types for the move and multiply execution unit
package mmx_pkg;

  // ****************************************************************
  // Opcode decode fields
  // ****************************************************************
  localparam logic [3:0] MMX_LINE_ZERO = 4'h0;
  localparam logic [3:0] MMX_LINE_QUICK = 4'h7;
  localparam logic [3:0] MMX_LINE_MULW = 4'hc;
  localparam logic [2:0] MMX_PBM_MODE = 3'h1;
  localparam logic [7:0] MMX_ASM_TOP = 8'h0e;
  localparam logic [2:0] MMX_MULW_OP = 3'h7;
  localparam logic [9:0] MMX_MULL_TOP = 10'h130;
  localparam logic [2:0] MMX_EA_AIND = 3'h2;
  localparam logic [2:0] MMX_EA_AIDX = 3'h6;
  localparam logic [2:0] MMX_EA_OTHER = 3'h7;
  localparam logic [2:0] MMX_EA_ABSL = 3'h1;

  // ****************************************************************
  // Direction and size codes
  // ****************************************************************
  localparam logic [2:0] MMX_DS_WORD_IN = 3'h4;
  localparam logic [2:0] MMX_DS_LONG_IN = 3'h5;
  localparam logic [2:0] MMX_DS_WORD_OUT = 3'h6;
  localparam logic [2:0] MMX_DS_LONG_OUT = 3'h7;
  localparam logic [1:0] MMX_SZ_BYTE = 2'h0;
  localparam logic [1:0] MMX_SZ_WORD = 2'h1;
  localparam logic [1:0] MMX_SZ_LONG = 2'h2;

  // ****************************************************************
  // Counts, steps and byte enables
  // ****************************************************************
  localparam logic [31:0] MMX_PBM_STEP = 32'h2;
  localparam logic [2:0] MMX_PBM_WORD_BYTES = 3'h2;
  localparam logic [2:0] MMX_PBM_LONG_BYTES = 3'h4;
  localparam logic [3:0] MMX_BE_BYTE = 4'h1;
  localparam logic [3:0] MMX_BE_WORD = 4'h3;
  localparam logic [3:0] MMX_BE_LONG = 4'hf;

  // ****************************************************************
  // Sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [4:0] {
    MMX_IDLE = 5'h01,
    MMX_PBUS = 5'h02,
    MMX_SBUS = 5'h04,
    MMX_MULHI = 5'h08,
    MMX_FINISH = 5'h10
  } mmx_state_e;

endpackage : mmx_pkg

// ===== hdl/mmx_exec.sv
// Decode and execution of peripheral, quick, alternate-space alternate_space_move and signed multiply
// What this block does
// - Peripheral move steps address by two
// - Peripheral move sends high byte first
// - Peripheral address is base plus sign-extended displacement
// - Even address upper lane, odd lower
// - Other bus widths still use alternate bytes
// - Decode peripheral move opcode and fields
// - Three-bit field picks direction and size
// - Quick load sign-extends eight-bit immediate
// - Decode quick load opcode and fields
// - Quick load sets N Z, clears V C
// - Alternate-space move needs supervisor state
// - Function code: destination on store, source load
// - Data register partial, address register sign-extended
// - Size field: byte, word, long
// - Register-type and direction bits in extension
// - Only alterable memory addressing modes accepted
// - Word multiply: 16 by 16 to 32
// - Long multiply: 32 by 32, 32 or 64
// - Multiply sets N Z V, clears C
// - Overflow only for 32-bit long result
// - Width bit picks low or high:low result
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
module mmx_exec (
  input wire logic clk,
  input wire logic rst,
  // Instruction issue
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [15:0] op_word,
  input wire logic [15:0] ext_word,
  input wire logic supervisor,
  input wire logic [31:0] ea_addr,
  input wire logic [31:0] src_operand,
  // Register file view
  input wire logic [7:0][31:0] data_file,
  input wire logic [7:0][31:0] addr_file,
  input wire logic [2:0] source_space_code,
  input wire logic [2:0] destination_space_code,
  // Register write-back
  output logic wr_en,
  output logic wr_addr_reg,
  output logic [2:0] wr_idx,
  output logic [3:0] wr_be,
  output logic [31:0] wr_data,
  // Condition codes, extend flag never driven
  output logic flags_we,
  output logic flag_n,
  output logic flag_z,
  output logic flag_v,
  output logic flag_c,
  // Memory bus request
  output logic mem_req,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [2:0] mem_space,
  output logic mem_lane_upper,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // Completion and traps
  output logic done,
  output logic priv_trap,
  output logic illegal_trap
);
  import mmx_pkg::*;

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    mmx_state_e state;
    logic wr_en, wr_addr_reg;
    logic [2:0] wr_idx;
    logic [3:0] wr_be;
    logic [31:0] wr_data;
    logic flags_we, flag_n, flag_z, flag_v, flag_c;
    logic mem_req, mem_write;
    logic [31:0] mem_addr;
    logic [1:0] mem_size;
    logic [2:0] mem_space;
    logic mem_lane_upper;
    logic [31:0] mem_wdata;
    logic done, priv_trap, illegal_trap;
    logic [31:0] xfer;
    logic [2:0] cnt;
    logic is_long, to_mem, addr_type;
    logic [2:0] ridx;
    logic [31:0] hi_data;
    logic [2:0] hi_idx;
  } mmx_state_s;

  mmx_state_s cur, next_cur;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic dec_pbm, dec_quick, dec_asm, dec_mulw, dec_mull, asm_mode_ok, mul_ovf;
  logic [2:0] ea_mode, ea_reg;
  logic [31:0] pbm_addr, quick_val, mul_a, mul_b, asm_src, pbm_load;
  logic signed [63:0] product;
  logic [7:0] lane_byte;

  assign ea_mode = op_word[5:3];
  assign ea_reg = op_word[2:0];
  assign dec_pbm = (op_word[15:12] == MMX_LINE_ZERO) && (ea_mode == MMX_PBM_MODE)
                   && op_word[8];
  assign dec_quick = (op_word[15:12] == MMX_LINE_QUICK) && !op_word[8];
  // size 11 is not an operation size
  assign dec_asm = (op_word[15:8] == MMX_ASM_TOP) && (op_word[7:6] != 2'h3)
                   && (ext_word[10:0] == 11'h000);
  assign dec_mulw = (op_word[15:12] == MMX_LINE_MULW) && (op_word[8:6] == MMX_MULW_OP);
  // long multiply decode, signed form only
  assign dec_mull = (op_word[15:6] == MMX_MULL_TOP) && !ext_word[15] && ext_word[11]
                    && (ext_word[9:3] == 7'h00);
  assign asm_mode_ok = ((ea_mode >= MMX_EA_AIND) && (ea_mode <= MMX_EA_AIDX))
                       || ((ea_mode == MMX_EA_OTHER) && (ea_reg <= MMX_EA_ABSL));
  assign pbm_addr = addr_file[ea_reg] + {{16{ext_word[15]}}, ext_word};
  assign quick_val = {{24{op_word[7]}}, op_word[7:0]};
  // Operands; word form uses only the low halves
  always_comb begin
    if (dec_mulw) begin
      mul_a = {{16{src_operand[15]}}, src_operand[15:0]};
      mul_b = {{16{data_file[op_word[11:9]][15]}}, data_file[op_word[11:9]][15:0]};
    end else begin
      mul_a = src_operand;
      mul_b = data_file[ext_word[14:12]];
    end
  end

  // one signed 32 by 32 multiplier serves both forms
  assign product = $signed(mul_a) * $signed(mul_b);
  // upper half not the sign extension of the lower half
  assign mul_ovf = product[63:32] != {32{product[31]}};
  // Register operand for an alternate-space store
  assign asm_src = ext_word[15] ? addr_file[ext_word[14:12]] : data_file[ext_word[14:12]];

  // byte taken from the lane the address picks
  assign lane_byte = cur.mem_lane_upper ? mem_rdata[15:8] : mem_rdata[7:0];
  // earlier bytes move up as later ones arrive
  assign pbm_load = {cur.xfer[23:0], lane_byte};
  assign issue_ready = cur.state == MMX_IDLE;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Pulses drop every cycle; the case below raises what it needs
  always_comb begin
    next_cur = cur;
    next_cur.wr_en = 1'b0;
    next_cur.flags_we = 1'b0;
    next_cur.done = 1'b0;
    next_cur.priv_trap = 1'b0;
    next_cur.illegal_trap = 1'b0;
    unique case (cur.state)
      MMX_IDLE: begin
        if (issue_valid) begin
          if (dec_pbm) begin
            // bit 7 store direction, bit 6 long size
            next_cur.to_mem = op_word[7];
            next_cur.is_long = op_word[6];
            next_cur.ridx = op_word[11:9];
            next_cur.cnt = op_word[6] ? MMX_PBM_LONG_BYTES : MMX_PBM_WORD_BYTES;
            // word source placed in the top half so high byte leads
            next_cur.xfer = op_word[6] ? data_file[op_word[11:9]]
                                       : {data_file[op_word[11:9]][15:0], 16'h0000};
            next_cur.mem_req = 1'b1;
            next_cur.mem_write = op_word[7];
            next_cur.mem_addr = pbm_addr;
            next_cur.mem_size = MMX_SZ_BYTE;
            next_cur.mem_space = destination_space_code;
            // lane fixed by the first address; steps of two keep it
            next_cur.mem_lane_upper = !pbm_addr[0];
            next_cur.mem_wdata = pbm_addr[0]
              ? {24'h000000, data_file[op_word[11:9]][op_word[6] ? 31 : 15 -: 8]}
              : {16'h0000, data_file[op_word[11:9]][op_word[6] ? 31 : 15 -: 8], 8'h00};
            next_cur.state = MMX_PBUS;
          end else if (dec_quick) begin
            next_cur.wr_en = 1'b1;
            next_cur.wr_addr_reg = 1'b0;
            next_cur.wr_idx = op_word[11:9];
            next_cur.wr_be = MMX_BE_LONG;
            next_cur.wr_data = quick_val;
            // N and Z from result, V and C cleared
            next_cur.flags_we = 1'b1;
            next_cur.flag_n = quick_val[31];
            next_cur.flag_z = quick_val == 32'h00000000;
            next_cur.flag_v = 1'b0;
            next_cur.flag_c = 1'b0;
            next_cur.done = 1'b1;
          end else if (dec_asm) begin
            if (!supervisor) begin
              // privilege trap with no operand cycle
              next_cur.priv_trap = 1'b1;
            end else if (!asm_mode_ok) begin
              next_cur.illegal_trap = 1'b1;
            end else begin
              // extension bit 15 register type, bit 11 direction
              next_cur.addr_type = ext_word[15];
              next_cur.ridx = ext_word[14:12];
              next_cur.to_mem = ext_word[11];
              next_cur.mem_req = 1'b1;
              next_cur.mem_write = ext_word[11];
              next_cur.mem_addr = ea_addr;
              // size code passed to the bus as is
              next_cur.mem_size = op_word[7:6];
              // store uses destination code, load uses source code
              next_cur.mem_space = ext_word[11] ? destination_space_code
                                                : source_space_code;
              next_cur.mem_lane_upper = 1'b0;
              next_cur.mem_wdata = asm_src;
              next_cur.state = MMX_SBUS;
            end
          end else if (dec_mulw || dec_mull) begin
            // full 32-bit product to Dn; low half to low register
            next_cur.wr_en = 1'b1;
            next_cur.wr_addr_reg = 1'b0;
            next_cur.wr_idx = dec_mulw ? op_word[11:9] : ext_word[14:12];
            next_cur.wr_be = MMX_BE_LONG;
            next_cur.wr_data = product[31:0];
            // N Z from result, carry cleared
            next_cur.flags_we = 1'b1;
            next_cur.flag_c = 1'b0;
            if (dec_mull && ext_word[10]) begin
              // high half follows in the next cycle
              next_cur.flag_n = product[63];
              next_cur.flag_z = product == 64'h0000000000000000;
              next_cur.flag_v = 1'b0;
              next_cur.hi_data = product[63:32];
              next_cur.hi_idx = ext_word[2:0];
              next_cur.state = MMX_MULHI;
            end else begin
              next_cur.flag_n = product[31];
              next_cur.flag_z = product[31:0] == 32'h00000000;
              // overflow only in the long 32-bit result form
              next_cur.flag_v = dec_mull && mul_ovf;
              next_cur.done = 1'b1;
            end
          end else begin
            // Anything outside this unit's set is refused
            next_cur.illegal_trap = 1'b1;
          end
        end
      end
      MMX_PBUS: begin
        if (mem_ack) begin
          next_cur.cnt = cur.cnt - 3'h1;
          // shift toward the next lower byte
          next_cur.xfer = cur.to_mem ? {cur.xfer[23:0], 8'h00} : pbm_load;
          if (cur.cnt == 3'h1) begin
            next_cur.mem_req = 1'b0;
            next_cur.state = MMX_FINISH;
            if (!cur.to_mem) begin
              // word load touches only the low 16 bits
              next_cur.wr_en = 1'b1;
              next_cur.wr_addr_reg = 1'b0;
              next_cur.wr_idx = cur.ridx;
              next_cur.wr_be = cur.is_long ? MMX_BE_LONG : MMX_BE_WORD;
              next_cur.wr_data = cur.is_long ? pbm_load : {16'h0000, pbm_load[15:0]};
            end
          end else begin
            // alternate bytes whatever the bus width
            next_cur.mem_addr = cur.mem_addr + MMX_PBM_STEP;
            next_cur.mem_wdata = cur.mem_lane_upper
              ? {16'h0000, cur.xfer[23:16], 8'h00}
              : {24'h000000, cur.xfer[23:16]};
          end
        end
      end
      MMX_SBUS: begin
        if (mem_ack) begin
          next_cur.mem_req = 1'b0;
          next_cur.state = MMX_FINISH;
          if (!cur.to_mem) begin
            next_cur.wr_en = 1'b1;
            next_cur.wr_addr_reg = cur.addr_type;
            next_cur.wr_idx = cur.ridx;
            // address register gets a sign-extended operand
            if (cur.addr_type) begin
              next_cur.wr_be = MMX_BE_LONG;
              unique case (cur.mem_size)
                MMX_SZ_BYTE: next_cur.wr_data = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
                MMX_SZ_WORD: next_cur.wr_data = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
                default: next_cur.wr_data = mem_rdata;
              endcase
            end else begin
              // data register keeps bits above the size
              next_cur.wr_data = mem_rdata;
              unique case (cur.mem_size)
                MMX_SZ_BYTE: next_cur.wr_be = MMX_BE_BYTE;
                MMX_SZ_WORD: next_cur.wr_be = MMX_BE_WORD;
                default: next_cur.wr_be = MMX_BE_LONG;
              endcase
            end
          end
        end
      end
      MMX_MULHI: begin
        // upper product half to the high register
        next_cur.wr_en = 1'b1;
        next_cur.wr_addr_reg = 1'b0;
        next_cur.wr_idx = cur.hi_idx;
        next_cur.wr_be = MMX_BE_LONG;
        next_cur.wr_data = cur.hi_data;
        next_cur.done = 1'b1;
        next_cur.state = MMX_IDLE;
      end
      MMX_FINISH: begin
        // One spare cycle lets the last write settle before the next issue
        next_cur.done = 1'b1;
        next_cur.state = MMX_IDLE;
      end
      default: begin
        next_cur.state = MMX_IDLE;
        next_cur.mem_req = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
      cur.state <= MMX_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the record
  assign wr_en = cur.wr_en;
  assign wr_addr_reg = cur.wr_addr_reg;
  assign wr_idx = cur.wr_idx;
  assign wr_be = cur.wr_be;
  assign wr_data = cur.wr_data;
  assign flags_we = cur.flags_we;
  assign flag_n = cur.flag_n;
  assign flag_z = cur.flag_z;
  assign flag_v = cur.flag_v;
  assign flag_c = cur.flag_c;
  assign mem_req = cur.mem_req;
  assign mem_write = cur.mem_write;
  assign mem_addr = cur.mem_addr;
  assign mem_size = cur.mem_size;
  assign mem_space = cur.mem_space;
  assign mem_lane_upper = cur.mem_lane_upper;
  assign mem_wdata = cur.mem_wdata;
  assign done = cur.done;
  assign priv_trap = cur.priv_trap;
  assign illegal_trap = cur.illegal_trap;

endmodule : mmx_exec

// ===== verification/mmx_mem_model.sv
// Memory bus partner: byte store with variable acknowledge delay
`timescale 1ns/100ps
module mmx_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] ack_wait,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic mem_lane_upper,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [256];
  logic [1:0] cnt;
  logic [31:0] junk;
  logic [31:0] rd;
  int i;
  int n;
  int sh;
  // Preset contents so a misplaced read never looks right by chance
  initial begin
    junk = 32'h1234_5678;
    for (i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 11);
  end
  // Lanes not carrying data show a pattern that changes every cycle
  always @(posedge clk) begin
    rd = ~junk;
    junk <= junk * 32'h0019_660d + 32'h3c6e_f35f;
    mem_ack <= 1'b0;
    if (rst) begin
      cnt <= 2'h0;
    end else if (mem_req && !mem_ack) begin
      if (cnt != ack_wait) begin
        cnt <= cnt + 2'h1;
      end else begin
        cnt <= 2'h0;
        mem_ack <= 1'b1;
        n = (mem_size == 2'h2) ? 4 : (mem_size == 2'h1) ? 2 : 1;
        sh = (n == 1 && mem_lane_upper) ? 8 : 0;
        // Lowest address holds the most significant byte
        for (i = 0; i < n; i++) begin
          if (mem_write) mem[8'(mem_addr + 32'(i))] <= mem_wdata[8 * (n - 1 - i) + sh +: 8];
          rd[8 * (n - 1 - i) + sh +: 8] = mem[8'(mem_addr + 32'(i))];
        end
      end
    end
    mem_rdata <= rd;
  end
endmodule : mmx_mem_model

// ===== verification/mmx_exec_assertions.sv
// Concurrent checks on the execution unit ports
`timescale 1ns/100ps
module mmx_exec_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire logic [15:0] op_word,
  input wire logic [15:0] ext_word,
  input wire logic supervisor,
  input wire logic [7:0][31:0] addr_file,
  input wire logic [2:0] source_space_code,
  input wire logic [2:0] destination_space_code,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic flags_we,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic flag_v,
  input wire logic flag_c,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [2:0] mem_space,
  input wire logic mem_lane_upper,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic done,
  input wire logic priv_trap
);
  import mmx_pkg::*;
  logic take, quick_op, pbm_op, alt_op, alt_ok;
  // Decode of the instruction taken at this edge
  assign take = issue_valid && issue_ready;
  assign quick_op = take && op_word[15:12] == MMX_LINE_QUICK && !op_word[8];
  assign pbm_op = take && op_word[15:12] == MMX_LINE_ZERO && op_word[8] && op_word[5:3] == 3'h1;
  assign alt_op = take && op_word[15:8] == MMX_ASM_TOP && op_word[7:6] != 2'h3;
  assign alt_ok = alt_op && (op_word[5:3] inside {[3'h2:3'h6]} || op_word[5:1] == 5'h1c);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  step_two_a: assert property (
    mem_req && mem_ack ##1 mem_req |-> mem_addr == $past(mem_addr) + MMX_PBM_STEP)
    else $error("peripheral address did not advance by two");
  lane_pick_a: assert property (
    mem_req && mem_ack ##1 mem_req |-> mem_lane_upper == !mem_addr[0] && $stable(mem_lane_upper))
    else $error("peripheral byte lane wrong");
  pbm_base_a: assert property (
    pbm_op |=> mem_req && mem_addr == $past(addr_file[op_word[2:0]]) + {{16{$past(ext_word[15])}}, $past(ext_word)})
    else $error("peripheral start address wrong");
  pbm_kind_a: assert property (
    pbm_op |=> mem_write == $past(op_word[7]) && mem_size == MMX_SZ_BYTE)
    else $error("peripheral direction or size wrong");
  quick_load_a: assert property (
    quick_op |=> wr_en && done && flags_we && !flag_v && !flag_c &&
      wr_data == {{24{$past(op_word[7])}}, $past(op_word[7:0])})
    else $error("quick load result wrong");
  quick_nz_a: assert property (
    quick_op ##1 flags_we |-> flag_n == wr_data[31] && flag_z == (wr_data == 32'h0))
    else $error("quick load sign or zero flag wrong");
  user_trap_a: assert property (
    alt_op && !supervisor |=> priv_trap && !mem_req && !done ##1 !mem_req)
    else $error("user state alternate move not trapped");
  alt_space_a: assert property (
    alt_ok && supervisor |=> mem_req && mem_write == $past(ext_word[11]) && mem_space ==
      ($past(ext_word[11]) ? $past(destination_space_code) : $past(source_space_code)))
    else $error("alternate move space code wrong");
  carry_clear_a: assert property (
    flags_we |-> !flag_c)
    else $error("carry flag set");
  req_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("bus request changed before acknowledge");
  cover property (pbm_op ##1 mem_req && mem_ack ##1 mem_req);
  cover property (alt_op && !supervisor);
  cover property (mem_req && !mem_ack ##1 mem_req && mem_ack);
endmodule : mmx_exec_assertions

bind mmx_exec mmx_exec_assertions i_mmx_exec_assertions (.*);

// ===== verification/tb.sv
// Self-checking bench for the move and multiply execution unit
`timescale 1ns/100ps
module tb;
  import mmx_pkg::*;
  logic clk, rst, issue_valid, issue_ready, supervisor, wr_en, wr_addr_reg, flags_we;
  logic flag_n, flag_z, flag_v, flag_c, mem_req, mem_write, mem_lane_upper, mem_ack;
  logic done, priv_trap, illegal_trap;
  logic [15:0] op_word, ext_word;
  logic [31:0] ea_addr, src_operand, wr_data, mem_addr, mem_wdata, mem_rdata;
  logic [7:0][31:0] data_file, addr_file;
  logic [2:0] source_space_code, destination_space_code, wr_idx, mem_space, spc;
  logic [3:0] wr_be, fl;
  logic [1:0] mem_size, ack_wait, trp;
  logic [39:0] wq[$];
  integer seed = 32'h5877;
  integer n_mismatch = 0;
  integer tests_run = 0;
  integer nack;
  // Every port meets the bench signal of the same name
  mmx_exec i_mmx_exec (.*);
  mmx_mem_model i_mmx_mem_model (.*);
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare one value with its expectation
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // Next register write seen, unknown when none is left
  function automatic logic [39:0] nxt();
    if (wq.size() == 0) return 40'hx;
    return wq.pop_front();
  endfunction : nxt
  // Issue one instruction and log writes, flags, bus cycles and traps until it ends
  task automatic run(input logic [15:0] op, input logic [15:0] ext);
    integer k;
    wq.delete();
    nack = 0;
    fl = 4'hx;
    @(posedge clk);
    issue_valid <= 1'b1;
    op_word <= op;
    ext_word <= ext;
    ack_wait <= 2'($random(seed));
    @(posedge clk);
    issue_valid <= 1'b0;
    for (k = 0; k < 40; k++) begin
      #1;
      if (wr_en) wq.push_back({wr_addr_reg, wr_idx, wr_be, wr_data});
      if (flags_we) fl = {flag_n, flag_z, flag_v, flag_c};
      if (mem_req && mem_ack) begin
        nack++;
        spc = mem_space;
      end
      trp = {priv_trap, illegal_trap};
      if (done || priv_trap || illegal_trap) break;
      @(posedge clk);
    end
    if (k == 40) chk(1'b0, 1'b1);
  endtask : run
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    integer i, k, n, r, d, sz;
    logic [31:0] v, adr, msk, sx;
    logic signed [63:0] p;
    logic [15:0] disp;
    logic [39:0] w;
    logic [5:0] okm [7];
    okm = '{6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38, 6'h39};
    rst = 1'b1;
    issue_valid = 1'b0;
    op_word = 16'h0;
    ext_word = 16'h0;
    supervisor = 1'b1;
    ea_addr = 32'h0;
    src_operand = 32'h0;
    ack_wait = 2'h0;
    source_space_code = 3'($random(seed));
    destination_space_code = source_space_code ^ 3'h7;
    for (i = 0; i < 8; i++) begin
      data_file[i] = $random(seed);
      addr_file[i] = $random(seed);
    end
    data_file[1] = 32'hffff_fff9;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // quick loads, zero and negative edges included
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'h80 : $random(seed);
      v = {{24{v[7]}}, v[7:0]};
      run({MMX_LINE_QUICK, 3'(i), 1'b0, v[7:0]}, 16'h0);
      chk(nxt(), {1'b0, 3'(i), 4'hf, v});
      chk(fl, {v[31], v == 32'h0, 2'b00});
    end
    for (i = 0; i < 6; i++) begin
      src_operand <= (i == 0) ? 32'h0 : $random(seed);
      run({MMX_LINE_MULW, 3'(i + 1), MMX_MULW_OP, 6'h0}, 16'h0);
      p = $signed(data_file[i + 1][15:0]) * $signed(src_operand[15:0]);
      chk(nxt(), {1'b0, 3'(i + 1), 4'hf, p[31:0]});
      chk(fl, {p[31], p[31:0] == 32'h0, 2'b00});
    end
    // long multiply, both widths, with and without overflow
    for (i = 0; i < 8; i++) begin
      src_operand <= (i == 4) ? 32'h0 : (i < 2) ? 32'h5 - 32'(10 * i) : $random(seed);
      d = (i < 2) ? 1 : i;
      sz = i % 2;
      run({MMX_MULL_TOP, 6'h0}, {1'b0, 3'(d), 1'b1, 1'(sz), 7'h0, 3'((d + 3) % 8)});
      p = $signed(data_file[d]) * $signed(src_operand);
      chk(nxt(), {1'b0, 3'(d), 4'hf, p[31:0]});
      if (sz) chk(nxt(), {1'b0, 3'((d + 3) % 8), 4'hf, p[63:32]});
      chk(fl, sz ? {p[63], p == 64'h0, 2'b00}
        : {p[31], p[31:0] == 32'h0, p[63:32] != {32{p[31]}}, 1'b0});
    end
    // peripheral store then load back, even and odd
    for (i = 0; i < 8; i++) begin
      sz = i % 2;
      n = sz ? 4 : 2;
      disp = $random(seed);
      disp[0] = addr_file[7 - i][0] ^ i[1];
      v = data_file[i];
      adr = addr_file[7 - i] + {{16{disp[15]}}, disp};
      run({4'h0, 3'(i), 2'b11, 1'(sz), 3'b001, 3'(7 - i)}, disp);
      chk(wq.size(), 0);
      chk(nack, n);
      for (k = 0; k < n; k++) chk(i_mmx_mem_model.mem[8'(adr + 32'(2 * k))], v[8 * (n - 1 - k) +: 8]);
      run({4'h0, 3'((i + 1) % 8), 2'b10, 1'(sz), 3'b001, 3'(7 - i)}, disp);
      chk(nxt(), {1'b0, 3'((i + 1) % 8), sz ? 4'hf : 4'h3, sz ? v : {16'h0, v[15:0]}});
    end
    // alternate-space store then load, every legal mode
    for (i = 0; i < 7; i++) begin
      sz = i % 3;
      n = 1 << sz;
      v = i[0] ? addr_file[i] : data_file[i];
      ea_addr <= $random(seed);
      run({MMX_ASM_TOP, 2'(sz), okm[i]}, {i[0], 3'(i), 1'b1, 11'h0});
      adr = ea_addr;
      chk(spc, destination_space_code);
      for (k = 0; k < n; k++) chk(i_mmx_mem_model.mem[8'(adr + 32'(k))], v[8 * (n - 1 - k) +: 8]);
      run({MMX_ASM_TOP, 2'(sz), okm[i]}, {~i[0], 3'(i), 1'b0, 11'h0});
      chk({spc, 4'(nack)}, {source_space_code, 4'h1});
      msk = (n == 4) ? 32'hffff_ffff : (32'h1 << (8 * n)) - 32'h1;
      sx = (n == 1) ? {{24{v[7]}}, v[7:0]} : (n == 2) ? {{16{v[15]}}, v[15:0]} : v;
      w = nxt();
      if (!i[0]) chk(w, {1'b1, 3'(i), 4'hf, sx});
      else chk({w[39:32], w[31:0] & msk}, {1'b0, 3'(i), 4'((1 << n) - 1), v & msk});
    end
    // user state refuses the move with no bus cycle
    supervisor <= 1'b0;
    run({MMX_ASM_TOP, 2'h2, 6'h10}, 16'h9800);
    chk({trp, 4'(nack), 4'(wq.size())}, {2'b10, 8'h0});
    supervisor <= 1'b1;
    for (i = 0; i < 4; i++) begin
      run({MMX_ASM_TOP, 2'h1, (i < 2) ? 6'(8 * i) : 6'h3a + 6'(2 * i - 4)}, 16'h8800);
      chk({trp, 4'(nack)}, {2'b01, 4'h0});
    end
    report_and_stop();
  end
endmodule : tb
